// file: src/pse_status_bank.sv
// status-extension and bypass control registers 15 to 18 of one copper port
`timescale 1ns/1ps
// What this block does
// (R1) register 15 bit 13 reads one: gigabit full duplex capable
// (R2) register 15 bit 12 reads one: gigabit half duplex; other bits zero
// (R3) register 16 bit 15 live descrambler lock, bit 14 latched lock error
// (R4) register 16 bit 13 latches a 100 Mb link disconnect
// (R5) register 16 bit 12 shows 100 Mb link active now
// (R6) register 16 bits 11 to 8 latch rx, tx, start and end delimiter errors
// (R7) register 17 bit 15 gigabit descrambler lock, bit 14 latched lock error
// (R8) register 17 bit 13 latches gigabit disconnect, bit 12 live link
// (R9) register 17 bits 11 to 7 latch gigabit errors incl. carrier extension
// (R10) register 17 bit 6 quirky partner seen, bit 5 crossover error
// (R11) register 18 bits 15 to 10: tx disable and pcs sub-block bypasses
// (R12) register 18 bit 9 skips the link fail inhibit timer
// (R13) register 18 bit 7, default one, blocks crossover fixing at forced speed
// (R14) register 18 bit 6 stops quirky partner detection and its flag
// (R15) register 18 bit 5 stops pair swap correction under autonegotiation
// (R16) register 18 bit 4 stops polarity correction on all subchannels
// (R17) register 18 bit 3, default one, parallel detect honours advertisement
// (R18) register 18 bit 2 disables the transmit pulse shaping filter
// (R19) register 18 bit 1 hands next page exchange to the host
// (R20) host then sends next pages and forces the resolved setup
// (R21) sticky bits survive software reset while sticky reset is enabled
// (R22) latched flags stay set until their register is read or a software reset
// (R23) reserved bits read zero and ignore writes
module pse_status_bank
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic swReset,
	input wire logic stickyResetEn,
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] rdData_ff,
	output logic rdValid_ff,
	input wire logic fxDescLocked,
	input wire logic fxLinkUp,
	input wire logic [5:0] fxEvent,
	input wire logic gigDescLocked,
	input wire logic gigLinkUp,
	input wire logic [6:0] gigEvent,
	input wire logic partnerQuirkSeen,
	input wire logic crossoverErrSeen,
	input wire logic basePageDone,
	input wire logic anRestart,
	output logic txDisable,
	output logic nibbleSymbolCoderBypass,
	output logic scramblerBypass,
	output logic descramblerBypass,
	output logic pcsRxBypass,
	output logic pcsTxBypass,
	output logic linkFailInhibitTimerBypass,
	output logic forcedCrossoverDisable,
	output logic quirkDetectDisable,
	output logic pairSwapCorrDisable,
	output logic polarityCorrDisable,
	output logic parallelDetectHonourAdv,
	output logic pulseShapeDisable,
	output logic autoNextPageDisable,
	output logic npHostOwned_ff
);
	pse_flag_if #(.W(pse_pkg::FX_FLAGS)) fxFl ();
	pse_flag_if #(.W(pse_pkg::GIG_FLAGS)) gigFl ();
	pse_ctrl_if ctl ();

	logic rdFx;
	logic rdGig;
	logic wrBypass;
	logic addrHit;
	logic [15:0] fxWord;
	logic [15:0] gigWord;
	logic [15:0] nxt_rdData;

	assign rdFx = regRd && (regAddr == pse_pkg::ADDR_FX_STAT);
	assign rdGig = regRd && (regAddr == pse_pkg::ADDR_GIG_STAT);
	assign wrBypass = regWr && (regAddr == pse_pkg::ADDR_BYPASS);
	assign addrHit = (regAddr == pse_pkg::ADDR_GIG_ABIL) ||
		(regAddr == pse_pkg::ADDR_FX_STAT) ||
		(regAddr == pse_pkg::ADDR_GIG_STAT) ||
		(regAddr == pse_pkg::ADDR_BYPASS);

	// event flags: read of the owning register or software reset clears them
	assign fxFl.event_in = fxEvent; // [R4] [R6]
	assign fxFl.clr = rdFx || swReset; // [R22]
	assign gigFl.event_in = gigEvent; // [R8] [R9]
	assign gigFl.clr = rdGig || swReset; // [R22]

	pse_sc_flags #(.W(pse_pkg::FX_FLAGS)) uFxFlags
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.fl(fxFl)
	);

	pse_sc_flags #(.W(pse_pkg::GIG_FLAGS)) uGigFlags
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.fl(gigFl)
	);

	// writes to registers 15 to 17 fall on no storage and are dropped
	assign ctl.wr = wrBypass; // [R23]
	assign ctl.wrData = regWrData;
	assign ctl.swReset = swReset;
	assign ctl.stickyEn = stickyResetEn; // [R21]

	pse_ctrl_reg uCtrl
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cr(ctl)
	);

	// 100 Mb status word
	always_comb
	begin
		fxWord = '0; // [R23]
		fxWord[pse_pkg::BIT_DESC_LOCK] = fxDescLocked; // [R3]
		fxWord[pse_pkg::BIT_LOCK_ERR] = fxFl.flags[pse_pkg::FLG_LOCK_ERR]; // [R3]
		fxWord[pse_pkg::BIT_DISC] = fxFl.flags[pse_pkg::FLG_DISC]; // [R4]
		fxWord[pse_pkg::BIT_LINK] = fxLinkUp; // [R5]
		fxWord[pse_pkg::BIT_RX_ERR] = fxFl.flags[pse_pkg::FLG_RX_ERR]; // [R6]
		fxWord[pse_pkg::BIT_TX_ERR] = fxFl.flags[pse_pkg::FLG_TX_ERR]; // [R6]
		fxWord[pse_pkg::BIT_START_DELIM] = fxFl.flags[pse_pkg::FLG_START_DELIM]; // [R6]
		fxWord[pse_pkg::BIT_END_DELIM] = fxFl.flags[pse_pkg::FLG_END_DELIM]; // [R6]
	end

	// gigabit status word, same layout plus carrier extension and partner bits
	always_comb
	begin
		gigWord = '0; // [R23]
		gigWord[pse_pkg::BIT_DESC_LOCK] = gigDescLocked; // [R7]
		gigWord[pse_pkg::BIT_LOCK_ERR] = gigFl.flags[pse_pkg::FLG_LOCK_ERR]; // [R7]
		gigWord[pse_pkg::BIT_DISC] = gigFl.flags[pse_pkg::FLG_DISC]; // [R8]
		gigWord[pse_pkg::BIT_LINK] = gigLinkUp; // [R8]
		gigWord[pse_pkg::BIT_RX_ERR] = gigFl.flags[pse_pkg::FLG_RX_ERR]; // [R9]
		gigWord[pse_pkg::BIT_TX_ERR] = gigFl.flags[pse_pkg::FLG_TX_ERR]; // [R9]
		gigWord[pse_pkg::BIT_START_DELIM] = gigFl.flags[pse_pkg::FLG_START_DELIM]; // [R9]
		gigWord[pse_pkg::BIT_END_DELIM] = gigFl.flags[pse_pkg::FLG_END_DELIM]; // [R9]
		gigWord[pse_pkg::BIT_CARRIER_EXT] = gigFl.flags[pse_pkg::FLG_CARRIER_EXT]; // [R9]
		// gated here too so a detector that lags the disable never shows through
		gigWord[pse_pkg::BIT_QUIRK] = partnerQuirkSeen &&
			!ctl.value[pse_pkg::CB_QUIRK_DIS]; // [R10] [R14]
		gigWord[pse_pkg::BIT_XOVER] = crossoverErrSeen; // [R10]
	end

	always_comb
	begin
		case (regAddr)
			pse_pkg::ADDR_GIG_ABIL: nxt_rdData = pse_pkg::GIG_ABIL_VAL; // [R1] [R2]
			pse_pkg::ADDR_FX_STAT: nxt_rdData = fxWord;
			pse_pkg::ADDR_GIG_STAT: nxt_rdData = gigWord;
			pse_pkg::ADDR_BYPASS: nxt_rdData = ctl.value; // [R23]
			default: nxt_rdData = '0;
		endcase
	end

	// read data is captured in the same cycle that clears the flags,
	// so the host sees the events up to and including the previous cycle
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdData_ff <= '0;
			rdValid_ff <= 1'b0;
		end
		else
		begin
			rdValid_ff <= regRd && addrHit;
			if (regRd && addrHit)
				rdData_ff <= nxt_rdData;
		end
	end

	// next page hand-over: the host owns the exchange after the base page
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			npHostOwned_ff <= 1'b0;
		else if (basePageDone && ctl.value[pse_pkg::CB_AUTO_NP])
			npHostOwned_ff <= 1'b1; // [R19]
		else if (anRestart || swReset)
			npHostOwned_ff <= 1'b0;
	end

	// control outputs come straight from the control flip-flops
	assign txDisable = ctl.value[pse_pkg::CB_TX_DIS]; // [R11]
	assign nibbleSymbolCoderBypass = ctl.value[pse_pkg::CB_CODER]; // [R11]
	assign scramblerBypass = ctl.value[pse_pkg::CB_SCRAMBLER]; // [R11]
	assign descramblerBypass = ctl.value[pse_pkg::CB_DESCRAMBLER]; // [R11]
	assign pcsRxBypass = ctl.value[pse_pkg::CB_PCS_RX]; // [R11]
	assign pcsTxBypass = ctl.value[pse_pkg::CB_PCS_TX]; // [R11]
	assign linkFailInhibitTimerBypass = ctl.value[pse_pkg::CB_LINK_FAIL_INHIBIT]; // [R12]
	assign forcedCrossoverDisable = ctl.value[pse_pkg::CB_XOVER_FORCED]; // [R13]
	assign quirkDetectDisable = ctl.value[pse_pkg::CB_QUIRK_DIS]; // [R14]
	assign pairSwapCorrDisable = ctl.value[pse_pkg::CB_PAIR_SWAP]; // [R15]
	assign polarityCorrDisable = ctl.value[pse_pkg::CB_POLARITY]; // [R16]
	assign parallelDetectHonourAdv = ctl.value[pse_pkg::CB_PAR_DETECT]; // [R17]
	assign pulseShapeDisable = ctl.value[pse_pkg::CB_PULSE_SHAPE]; // [R18]
	assign autoNextPageDisable = ctl.value[pse_pkg::CB_AUTO_NP]; // [R19]

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	property p_abil_read;
		regRd && regAddr == pse_pkg::ADDR_GIG_ABIL |=>
			rdValid_ff && rdData_ff == pse_pkg::GIG_ABIL_VAL;
	endproperty
	a_abil_read: assert property (p_abil_read) else $error("ability word wrong"); // [R1]

	property p_fx_live;
		rdFx |=> rdData_ff[pse_pkg::BIT_DESC_LOCK] == $past(fxDescLocked) &&
			rdData_ff[pse_pkg::BIT_LINK] == $past(fxLinkUp);
	endproperty
	a_fx_live: assert property (p_fx_live) else $error("live 100 Mb bits wrong"); // [R5]

	property p_fx_disc_seen;
		fxEvent[pse_pkg::FLG_DISC] && !swReset ##1 rdFx |=>
			rdData_ff[pse_pkg::BIT_DISC];
	endproperty
	a_fx_disc_seen: assert property (p_fx_disc_seen) else $error("disconnect not latched"); // [R4]

	property p_gig_cext;
		gigEvent[pse_pkg::FLG_CARRIER_EXT] && !swReset ##1 rdGig |=>
			rdData_ff[pse_pkg::BIT_CARRIER_EXT];
	endproperty
	a_gig_cext: assert property (p_gig_cext) else $error("carrier ext not latched"); // [R9]

	property p_read_clears;
		rdFx && fxEvent == '0 |=> fxFl.flags == '0;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // [R22]

	property p_fx_reserved;
		rdFx ##1 rdValid_ff && !regRd |=> rdData_ff[7:0] == '0 && $stable(rdData_ff);
	endproperty
	a_fx_reserved: assert property (p_fx_reserved) else $error("reserved bits set"); // [R23]

	property p_quirk_gate;
		rdGig && ctl.value[pse_pkg::CB_QUIRK_DIS] |=> !rdData_ff[pse_pkg::BIT_QUIRK];
	endproperty
	a_quirk_gate: assert property (p_quirk_gate) else $error("quirk flag not masked"); // [R14]

	property p_np_host;
		basePageDone && autoNextPageDisable |=> npHostOwned_ff [*2] or
			(npHostOwned_ff ##1 1'b1);
	endproperty
	a_np_host: assert property (p_np_host) else $error("next page not handed over"); // [R19]

	property p_unmapped;
		regRd && !addrHit |=> !rdValid_ff;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("answered unmapped address"); // [R23]

	property p_bypass_read;
		regRd && regAddr == pse_pkg::ADDR_BYPASS |=> rdData_ff == $past(ctl.value) &&
			(rdData_ff & ~pse_pkg::CTRL_WR_MASK) == '0;
	endproperty
	a_bypass_read: assert property (p_bypass_read) else $error("control readback wrong"); // [R23]

	property p_gig_live;
		rdGig |=> rdData_ff[pse_pkg::BIT_DESC_LOCK] == $past(gigDescLocked) &&
			rdData_ff[pse_pkg::BIT_LINK] == $past(gigLinkUp) &&
			rdData_ff[pse_pkg::BIT_XOVER] == $past(crossoverErrSeen);
	endproperty
	a_gig_live: assert property (p_gig_live) else $error("live gigabit bits wrong"); // [R7] [R8] [R10]

	property p_quirk_shown;
		rdGig && !ctl.value[pse_pkg::CB_QUIRK_DIS] |=>
			rdData_ff[pse_pkg::BIT_QUIRK] == $past(partnerQuirkSeen);
	endproperty
	a_quirk_shown: assert property (p_quirk_shown) else $error("quirky partner not shown"); // [R10]

	property p_gig_reserved;
		rdGig |=> rdData_ff[pse_pkg::BIT_XOVER-1:0] == '0;
	endproperty
	a_gig_reserved: assert property (p_gig_reserved) else $error("gigabit reserved bits set"); // [R23]

	property p_fx_lock_err;
		fxEvent[pse_pkg::FLG_LOCK_ERR] && !swReset ##1 rdFx |=>
			rdData_ff[pse_pkg::BIT_LOCK_ERR];
	endproperty
	a_fx_lock_err: assert property (p_fx_lock_err) else $error("lock error not latched"); // [R3]

	property p_gig_disc_seen;
		gigEvent[pse_pkg::FLG_DISC] && !swReset ##1 rdGig |=>
			rdData_ff[pse_pkg::BIT_DISC];
	endproperty
	a_gig_disc_seen: assert property (p_gig_disc_seen) else $error("gig disconnect lost"); // [R8]

	property p_gig_read_clears;
		rdGig && gigEvent == '0 |=> gigFl.flags == '0;
	endproperty
	a_gig_read_clears: assert property (p_gig_read_clears) else $error("gig read no clear"); // [R22]

	property p_np_clear;
		(anRestart || swReset) && !(basePageDone && autoNextPageDisable) |=>
			!npHostOwned_ff;
	endproperty
	a_np_clear: assert property (p_np_clear) else $error("next page ownership kept"); // [R19]

	c_flag_read: cover property (fxEvent[pse_pkg::FLG_RX_ERR] ##1 rdFx);
	c_bypass_wr: cover property (wrBypass ##1 rdValid_ff);
	c_np_host: cover property (basePageDone && autoNextPageDisable);
	c_set_on_clear: cover property (rdGig && gigEvent != '0);
endmodule

// file: src/pse_pkg.sv
// constants for the status-extension and bypass register bank
package pse_pkg;
	localparam logic [4:0] ADDR_GIG_ABIL = 5'h0f;
	localparam logic [4:0] ADDR_FX_STAT = 5'h10;
	localparam logic [4:0] ADDR_GIG_STAT = 5'h11;
	localparam logic [4:0] ADDR_BYPASS = 5'h12;
	localparam logic [15:0] GIG_ABIL_VAL = 16'h3000;
	localparam logic [15:0] CTRL_RST = 16'h0088;
	localparam logic [15:0] CTRL_STICKY = 16'h00fa;
	localparam logic [15:0] CTRL_WR_MASK = 16'hfefe;
	localparam int FX_FLAGS = 6;
	localparam int GIG_FLAGS = 7;
	// flag bank indexes, shared by both banks except FLG_CARRIER_EXT, which only the gigabit bank has
	localparam int FLG_END_DELIM = 0;
	localparam int FLG_START_DELIM = 1;
	localparam int FLG_TX_ERR = 2;
	localparam int FLG_RX_ERR = 3;
	localparam int FLG_DISC = 4;
	localparam int FLG_LOCK_ERR = 5;
	localparam int FLG_CARRIER_EXT = 6;
	// status word bit positions
	localparam int BIT_DESC_LOCK = 15;
	localparam int BIT_LOCK_ERR = 14;
	localparam int BIT_DISC = 13;
	localparam int BIT_LINK = 12;
	localparam int BIT_RX_ERR = 11;
	localparam int BIT_TX_ERR = 10;
	localparam int BIT_START_DELIM = 9;
	localparam int BIT_END_DELIM = 8;
	localparam int BIT_CARRIER_EXT = 7;
	localparam int BIT_QUIRK = 6;
	localparam int BIT_XOVER = 5;
	// bypass control bit positions
	localparam int CB_TX_DIS = 15;
	localparam int CB_CODER = 14;
	localparam int CB_SCRAMBLER = 13;
	localparam int CB_DESCRAMBLER = 12;
	localparam int CB_PCS_RX = 11;
	localparam int CB_PCS_TX = 10;
	localparam int CB_LINK_FAIL_INHIBIT = 9;
	localparam int CB_XOVER_FORCED = 7;
	localparam int CB_QUIRK_DIS = 6;
	localparam int CB_PAIR_SWAP = 5;
	localparam int CB_POLARITY = 4;
	localparam int CB_PAR_DETECT = 3;
	localparam int CB_PULSE_SHAPE = 2;
	localparam int CB_AUTO_NP = 1;
endpackage

// file: src/pse_links_if.sv
// interfaces between the register bank and its flag and control helpers
`timescale 1ns/1ps
interface pse_flag_if #(parameter int W = 6);
	logic [W-1:0] event_in;
	logic clr;
	logic [W-1:0] flags;
	modport bank (input event_in, input clr, output flags);
	modport user (output event_in, output clr, input flags);
endinterface

interface pse_ctrl_if;
	logic wr;
	logic [15:0] wrData;
	logic swReset;
	logic stickyEn;
	logic [15:0] value;
	modport reg_side (input wr, input wrData, input swReset, input stickyEn, output value);
	modport user (output wr, output wrData, output swReset, output stickyEn, input value);
endinterface

// file: src/pse_sc_flags.sv
// bank of self-clearing event flags, cleared by a read of their register
`timescale 1ns/1ps
module pse_sc_flags #(parameter int W = 6)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	pse_flag_if.bank fl
);
	logic [W-1:0] flags_ff;

	// a new event wins over the clear of the same cycle
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			flags_ff <= '0;
		else
			flags_ff <= fl.event_in | (flags_ff & ~{W{fl.clr}}); // [R22]
	end

	assign fl.flags = flags_ff;

	property p_set_wins;
		@(posedge clk_sys) disable iff (!arst_n)
		|fl.event_in |=> ((flags_ff & $past(fl.event_in)) == $past(fl.event_in));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost in flag bank"); // [R22]

	property p_hold_no_clear;
		@(posedge clk_sys) disable iff (!arst_n)
		!fl.clr |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff));
	endproperty
	a_hold_no_clear: assert property (p_hold_no_clear) else $error("flag dropped unread"); // [R22]
endmodule

// file: src/pse_ctrl_reg.sv
// bypass control word with sticky bits kept over software reset
`timescale 1ns/1ps
module pse_ctrl_reg
(
	input wire logic clk_sys,
	input wire logic arst_n,
	pse_ctrl_if.reg_side cr
);
	logic [15:0] ctrl_ff;
	logic [15:0] nxt_ctrl;

	// software reset takes priority over a write in the same cycle
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (cr.swReset)
		begin
			if (cr.stickyEn)
				nxt_ctrl = (ctrl_ff & pse_pkg::CTRL_STICKY) |
					(pse_pkg::CTRL_RST & ~pse_pkg::CTRL_STICKY); // [R21]
			else
				nxt_ctrl = pse_pkg::CTRL_RST; // [R21]
		end
		else if (cr.wr)
			nxt_ctrl = cr.wrData & pse_pkg::CTRL_WR_MASK; // [R23] [R11]
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_ff <= pse_pkg::CTRL_RST; // [R11] [R13] [R17]
		else
			ctrl_ff <= nxt_ctrl;
	end

	assign cr.value = ctrl_ff;

	property p_sticky_kept;
		@(posedge clk_sys) disable iff (!arst_n)
		cr.swReset && cr.stickyEn |=>
			((ctrl_ff & pse_pkg::CTRL_STICKY) == ($past(ctrl_ff) & pse_pkg::CTRL_STICKY));
	endproperty
	a_sticky_kept: assert property (p_sticky_kept) else $error("sticky bit lost"); // [R21]

	property p_soft_default;
		@(posedge clk_sys) disable iff (!arst_n)
		cr.swReset && !cr.stickyEn |=> ctrl_ff == pse_pkg::CTRL_RST;
	endproperty
	a_soft_default: assert property (p_soft_default) else $error("bad soft default"); // [R21]

	property p_wr_mask;
		@(posedge clk_sys) disable iff (!arst_n)
		cr.wr && !cr.swReset |=> ctrl_ff == ($past(cr.wrData) & pse_pkg::CTRL_WR_MASK);
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("control write wrong"); // [R23]

	c_sticky_kept: cover property (@(posedge clk_sys) cr.swReset && cr.stickyEn);
endmodule

// file: dv/pse_host_model.sv
// management host model driving the inside face of the serial management port
`timescale 1ns/1ps
module pse_host_model
(
	input wire logic clk_sys,
	output logic [4:0] regAddr,
	output logic [15:0] regWrData,
	output logic regWr,
	output logic regRd,
	input wire logic [15:0] rdData_ff,
	input wire logic rdValid_ff
);
	initial
	begin
		regAddr = 5'h00;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// released lines show the inverse so a stale value cannot pass
	task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
		@(posedge clk_sys);
		#1;
		regAddr = a;
		regRd = 1'b1;
		@(posedge clk_sys);
		#1;
		regRd = 1'b0;
		regAddr = ~a;
		d = rdData_ff;
		v = rdValid_ff;
	endtask

	// writes one register for one cycle, then drives the inverse of address and data
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		regAddr = a;
		regWrData = d;
		regWr = 1'b1;
		@(posedge clk_sys);
		#1;
		regWr = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
endmodule

// file: dv/pse_status_bank_tb.sv
// self-checking bench for the status-extension and bypass register bank
`timescale 1ns/1ps
module pse_status_bank_tb;
	logic clk_sys, arst_n, swReset, stickyResetEn;
	logic [4:0] regAddr;
	logic [15:0] regWrData, rdData_ff;
	logic regWr, regRd, rdValid_ff, npHostOwned_ff;
	logic fxDescLocked, fxLinkUp, gigDescLocked, gigLinkUp;
	logic partnerQuirkSeen, crossoverErrSeen, basePageDone, anRestart;
	logic [5:0] fxEvent;
	logic [6:0] gigEvent;
	wire logic [15:0] ctrlOut;
	int errorCnt, testsRun, mCtrl, mFx, mGig, mNp;
	logic [15:0] mLast, d;
	logic v;

	assign ctrlOut[8] = 1'b0;
	assign ctrlOut[0] = 1'b0;

	pse_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff));

	pse_status_bank i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .swReset(swReset),
		.stickyResetEn(stickyResetEn), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
		.fxDescLocked(fxDescLocked), .fxLinkUp(fxLinkUp), .fxEvent(fxEvent),
		.gigDescLocked(gigDescLocked), .gigLinkUp(gigLinkUp), .gigEvent(gigEvent),
		.partnerQuirkSeen(partnerQuirkSeen), .crossoverErrSeen(crossoverErrSeen),
		.basePageDone(basePageDone), .anRestart(anRestart), .txDisable(ctrlOut[15]),
		.nibbleSymbolCoderBypass(ctrlOut[14]), .scramblerBypass(ctrlOut[13]),
		.descramblerBypass(ctrlOut[12]), .pcsRxBypass(ctrlOut[11]),
		.pcsTxBypass(ctrlOut[10]), .linkFailInhibitTimerBypass(ctrlOut[9]),
		.forcedCrossoverDisable(ctrlOut[7]), .quirkDetectDisable(ctrlOut[6]),
		.pairSwapCorrDisable(ctrlOut[5]), .polarityCorrDisable(ctrlOut[4]),
		.parallelDetectHonourAdv(ctrlOut[3]), .pulseShapeDisable(ctrlOut[2]),
		.autoNextPageDisable(ctrlOut[1]), .npHostOwned_ff(npHostOwned_ff));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic endSim();
		if (errorCnt == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		testsRun++;
		if (g !== e)
		begin
			errorCnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// event vector index to status word bit
	function automatic int evmap(input int ev);
		return ((ev & 15) << 8) | (((ev >> 4) & 1) << 13) | (((ev >> 5) & 1) << 14)
			| (((ev >> 6) & 1) << 7);
	endfunction

	task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] rd;
		logic rv;
		i_host.rd(a, rd, rv);
		chk("rdValid", 16'h0001, {15'h0000, rv});
		chk("rdData", e, rd);
		mLast = e;
	endtask

	// live bits are held steady across the read, flags clear once read
	task automatic rdStat(input logic [4:0] a);
		int e;
		if (a == pse_pkg::ADDR_FX_STAT)
		begin
			e = mFx | (fxDescLocked << 15) | (fxLinkUp << 12);
			mFx = 0;
		end
		else
		begin
			e = mGig | (gigDescLocked << 15) | (gigLinkUp << 12)
				| ((partnerQuirkSeen && !mCtrl[6]) << 6) | (crossoverErrSeen << 5);
			mGig = 0;
		end
		rdchk(a, 16'(e));
	endtask

	task automatic doWr(input logic [4:0] a, input logic [15:0] w);
		i_host.wr(a, w);
		if (a == pse_pkg::ADDR_BYPASS)
			mCtrl = w & 16'hfefe;
		chk("ctrlOut", 16'(mCtrl), ctrlOut);
	endtask

	task automatic pulseEv(input logic [5:0] f, input logic [6:0] g);
		@(posedge clk_sys);
		#1;
		fxEvent = f;
		gigEvent = g;
		@(posedge clk_sys);
		#1;
		fxEvent = 6'h00;
		gigEvent = 7'h00;
		mFx |= evmap(f);
		mGig |= evmap(g);
	endtask

	task automatic sr(input logic en);
		@(posedge clk_sys);
		#1;
		stickyResetEn = en;
		swReset = 1'b1;
		@(posedge clk_sys);
		#1;
		swReset = 1'b0;
		mFx = 0;
		mGig = 0;
		mNp = 0;
		mCtrl = en ? (mCtrl & pse_pkg::CTRL_STICKY) : pse_pkg::CTRL_RST;
		chk("ctrlOut", 16'(mCtrl), ctrlOut);
		chk("npHostOwned", 16'(mNp), {15'h0000, npHostOwned_ff});
	endtask

	// set wins over restart
	task automatic pg(input logic b, input logic r);
		@(posedge clk_sys);
		#1;
		basePageDone = b;
		anRestart = r;
		@(posedge clk_sys);
		#1;
		basePageDone = 1'b0;
		anRestart = 1'b0;
		if (b && mCtrl[1])
			mNp = 1;
		else if (r)
			mNp = 0;
		chk("npHostOwned", 16'(mNp), {15'h0000, npHostOwned_ff});
	endtask

	initial
	begin
		#(25ns * 8000);
		errorCnt++;
		endSim();
	end

	initial
	begin
		void'($urandom(32'h04f5));
		{swReset, fxDescLocked, fxLinkUp, gigDescLocked, gigLinkUp} = 5'h00;
		{partnerQuirkSeen, crossoverErrSeen, basePageDone, anRestart} = 4'h0;
		fxEvent = 6'h00;
		gigEvent = 7'h00;
		stickyResetEn = 1'b1;
		arst_n = 1'b0;
		errorCnt = 0;
		testsRun = 0;
		mCtrl = pse_pkg::CTRL_RST;
		{mFx, mGig, mNp} = '0;
		mLast = 16'h0000;
		repeat (2) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		chk("ctrlOut", pse_pkg::CTRL_RST, ctrlOut);
		rdchk(pse_pkg::ADDR_GIG_ABIL, pse_pkg::GIG_ABIL_VAL);
		rdStat(pse_pkg::ADDR_FX_STAT);
		rdStat(pse_pkg::ADDR_GIG_STAT);
		rdchk(pse_pkg::ADDR_BYPASS, pse_pkg::CTRL_RST);
		doWr(pse_pkg::ADDR_BYPASS, 16'hffff);
		doWr(pse_pkg::ADDR_GIG_ABIL, 16'hffff);
		doWr(pse_pkg::ADDR_FX_STAT, 16'hffff);
		rdchk(pse_pkg::ADDR_GIG_ABIL, pse_pkg::GIG_ABIL_VAL);
		rdchk(pse_pkg::ADDR_BYPASS, 16'(mCtrl));
		i_host.rd(5'h13, d, v);
		chk("rdValid", 16'h0000, {15'h0000, v});
		chk("rdData", mLast, d);
		for (int b = 15; b >= 0; b--)
			doWr(pse_pkg::ADDR_BYPASS, 16'h0001 << b);
		pulseEv(6'h3f, 7'h7f);
		doWr(pse_pkg::ADDR_BYPASS, 16'hffff);
		sr(1'b1);
		rdStat(pse_pkg::ADDR_GIG_STAT);
		sr(1'b0);
		pulseEv(6'h3f, 7'h7f);
		rdStat(pse_pkg::ADDR_FX_STAT);
		rdStat(pse_pkg::ADDR_GIG_STAT);
		rdStat(pse_pkg::ADDR_FX_STAT);
		rdStat(pse_pkg::ADDR_GIG_STAT);
		// an event in the very cycle of the read must survive the clear
		fork
			rdStat(pse_pkg::ADDR_GIG_STAT);
			pulseEv(6'h00, 7'h7f);
		join
		rdStat(pse_pkg::ADDR_GIG_STAT);
		doWr(pse_pkg::ADDR_BYPASS, 16'h0002);
		pg(1'b1, 1'b0);
		i_host.wr(pse_pkg::ADDR_BYPASS, 16'h0002);
		pg(1'b1, 1'b1);
		pg(1'b0, 1'b1);
		pg(1'b1, 1'b0);
		sr(1'b1);
		doWr(pse_pkg::ADDR_BYPASS, 16'h0000);
		pg(1'b1, 1'b0);
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk_sys);
			#1;
			{fxDescLocked, fxLinkUp, gigDescLocked, gigLinkUp} = 4'($urandom);
			{partnerQuirkSeen, crossoverErrSeen} = 2'($urandom);
			doWr(pse_pkg::ADDR_BYPASS, 16'($urandom));
			doWr(5'($urandom_range(15, 31)), 16'($urandom));
			pulseEv(6'($urandom), 7'($urandom));
			rdStat(pse_pkg::ADDR_FX_STAT);
			rdStat(pse_pkg::ADDR_GIG_STAT);
		end
		endSim();
	end
endmodule
